/* src/fpp_defs.svh */
`ifndef FPP_DEFS_SVH
`define FPP_DEFS_SVH

// Register byte offsets
`define FPP_OFS_FCTL1 8'h00
`define FPP_OFS_FCTL2 8'h04
`define FPP_OFS_EBLO 8'h08
`define FPP_OFS_EBHI 8'h0C
`define FPP_OFS_OVLC 8'h10
`define FPP_OFS_FSTAT 8'h14

// flash_control_one fields
`define FPP_FC1_P 0
`define FPP_FC1_E 1
`define FPP_FC1_PVFY 2
`define FPP_FC1_EVFY 3
`define FPP_FC1_PSET 4
`define FPP_FC1_ESET 5
`define FPP_FC1_SWEN 6

// ram_overlay_control fields
`define FPP_OVL_SEL_LSB 0
`define FPP_OVL_EMU 3

// flash_status_reg fields
`define FPP_ST_PGM 0
`define FPP_ST_ERS 1
`define FPP_ST_VFY 2
`define FPP_ST_ERR 7

// Reset values
`define FPP_RST_REG8 8'h00
`define FPP_RST_OVL 4'h0

// Bus answers
`define FPP_RESP_OKAY 2'h0
`define FPP_RESP_SLVERR 2'h2

`endif

/* src/fpp_pkg.sv */
`default_nettype none

package fpp_pkg;

	// Processor-side events watched during program or erase
	typedef struct packed {
		logic flash_read;
		logic exc_start;
		logic exc_excluded;
		logic sleep_exec;
		logic bus_release;
	} fpp_cpu_evt_s;

	// Protection state
	typedef enum logic [2:0] {
		FPP_IDLE = 3'b001,
		FPP_BUSY = 3'b010,
		FPP_ERRP = 3'b100
	} fpp_state_e;

endpackage : fpp_pkg

`default_nettype wire

/* src/fpp_top.sv */
// Overview of operation
// RULE1: Software protection blocks program and erase entry
// RULE2: Erase only blocks selected; programming unaffected
// RULE3: Both selects zero means nothing erasable
// RULE4: Emulation enable protects all; verify still allowed
// RULE5: Software keeps selects zero when not erasing
// RULE6: Software clears emulation before real programming
// RULE7: Malfunction sets error flag, aborts operation
// RULE8: Error state keeps registers, blocks re-entry
// RULE9: Verify stays possible during error protection
// RULE10: Flash read during operation sets error
// RULE11: Exception start sets error, some excluded
// RULE12: Sleep during operation sets error flag
// RULE13: Bus release during operation sets error
// RULE14: Only pin, watchdog, hardware standby release; code releases on aresetn, watchdog or hardware standby
// RULE15: P or E set means busy; NMI masked
// RULE16: Registers writable in error; software standby clears
// RULE17: Only listed conditions detected as errors
// RULE18: RAM overlays flash, reachable both addresses
// RULE19: Emulation one, select zero overlays first block
// RULE20: Clearing emulation removes the overlay
// RULE21: Software arms watchdog when setting operation bits
// RULE22: P and E cleared by reset, standby, enables
// RULE23: Write-enable pin low initialises registers
// RULE24: Error flag read-only, cleared only by release
`include "fpp_defs.svh"
`default_nettype none

module fpp_top
	import fpp_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int FLASH_AW = 18,
	parameter int OVL_AW = 12
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// System conditions
	input wire logic write_enable_pin,
	input wire logic watchdog_reset,
	input wire logic hw_standby,
	input wire logic sw_standby,
	// Processor events
	input wire fpp_cpu_evt_s cpu_evt,
	input wire logic nmi_in,
	output logic nmi_out,
	// Flash array control
	output logic program_mode,
	output logic erase_mode,
	output logic verify_mode,
	output logic [15:0] erase_block_en,
	output logic flash_error_flag,
	// RAM overlay
	input wire logic [FLASH_AW-1:0] cpu_flash_addr,
	output logic overlay_hit,
	output logic [OVL_AW-1:0] overlay_ram_addr
);

	// ----------------------------------------------------------
	// Register state
	// ----------------------------------------------------------
	logic [7:0] fctl1_ff;
	logic [7:0] fctl2_ff;
	logic [7:0] eblo_ff;
	logic [7:0] ebhi_ff;
	logic [3:0] ovlc_ff;
	fpp_state_e state_ff;
	fpp_state_e nxt_state;

	// ----------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------
	logic aw_have_ff;
	logic w_have_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [7:0] w_byte_ff;
	logic w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	wire wr_en = wr_fire && w_strb_ff;
	wire wa_fc1 = aw_addr_ff == ADDR_W'(`FPP_OFS_FCTL1);
	wire wa_fc2 = aw_addr_ff == ADDR_W'(`FPP_OFS_FCTL2);
	wire wa_eblo = aw_addr_ff == ADDR_W'(`FPP_OFS_EBLO);
	wire wa_ebhi = aw_addr_ff == ADDR_W'(`FPP_OFS_EBHI);
	wire wa_ovl = aw_addr_ff == ADDR_W'(`FPP_OFS_OVLC);
	wire wa_stat = aw_addr_ff == ADDR_W'(`FPP_OFS_FSTAT);
	wire wa_hit = wa_fc1 || wa_fc2 || wa_eblo || wa_ebhi || wa_ovl || wa_stat;

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_byte_ff <= 8'h00;
			w_strb_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `FPP_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_have_ff <= 1'b1;
				w_byte_ff <= s_axi_wdata[7:0];
				w_strb_ff <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wa_hit ? `FPP_RESP_OKAY : `FPP_RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Protection decode
	// ----------------------------------------------------------
	wire pin_wen_ok = write_enable_pin;
	wire sw_wen_on = fctl1_ff[`FPP_FC1_SWEN];
	wire p_bit = fctl1_ff[`FPP_FC1_P];
	wire e_bit = fctl1_ff[`FPP_FC1_E];
	wire emu_on = ovlc_ff[`FPP_OVL_EMU];
	wire [15:0] eb_sel = {ebhi_ff, eblo_ff};
	wire in_error = state_ff == FPP_ERRP;
	wire in_progress = p_bit || e_bit; // RULE15
	wire release_err = watchdog_reset || hw_standby; // RULE14
	wire standby_any = sw_standby || hw_standby;
	wire init_all = watchdog_reset || standby_any;
	wire init_pin = !pin_wen_ok; // RULE23
	wire sw_protect = emu_on; // RULE4
	wire pe_block = in_error || sw_protect || !pin_wen_ok; // RULE1 RULE8
	wire any_blk = |eb_sel; // RULE3

	// Error sources; nothing else is watched
	wire evt_exc = cpu_evt.exc_start && !cpu_evt.exc_excluded; // RULE11
	wire evt_any = cpu_evt.flash_read // RULE10
		|| evt_exc
		|| cpu_evt.sleep_exec // RULE12
		|| cpu_evt.bus_release; // RULE13
	wire err_hit = in_progress && evt_any; // RULE17

	// Next flash_control_one from software, with enables applied
	wire [7:0] fc1_wr = (wr_en && wa_fc1) ? w_byte_ff : fctl1_ff;
	wire [7:0] fc1_sw = {1'b0, fc1_wr[6:0]};
	wire pe_keep = fc1_sw[`FPP_FC1_SWEN] && pin_wen_ok; // RULE22
	wire [7:0] nxt_fctl1 = pe_keep ? fc1_sw : (fc1_sw & 8'hFC);

	// ----------------------------------------------------------
	// Protection state
	// ----------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			FPP_IDLE:
				if (err_hit)
					nxt_state = FPP_ERRP; // RULE7
				else if (in_progress)
					nxt_state = FPP_BUSY;
			FPP_BUSY:
				if (err_hit)
					nxt_state = FPP_ERRP; // RULE7
				else if (!in_progress)
					nxt_state = FPP_IDLE;
			FPP_ERRP:
				if (release_err)
					nxt_state = FPP_IDLE; // RULE14 RULE24
			default:
				nxt_state = FPP_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || release_err)
			state_ff <= FPP_IDLE; // RULE14
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || init_all)
		begin
			fctl1_ff <= `FPP_RST_REG8; // RULE22 RULE16
			fctl2_ff <= `FPP_RST_REG8;
			eblo_ff <= `FPP_RST_REG8;
			ebhi_ff <= `FPP_RST_REG8;
		end
		else if (init_pin)
		begin
			fctl1_ff <= `FPP_RST_REG8; // RULE23 RULE22
			eblo_ff <= `FPP_RST_REG8;
			ebhi_ff <= `FPP_RST_REG8;
			if (wr_en && wa_fc2)
				fctl2_ff <= w_byte_ff;
		end
		else
		begin
			// Stays writable in error protection
			fctl1_ff <= nxt_fctl1; // RULE16 RULE8
			if (wr_en && wa_fc2)
				fctl2_ff <= w_byte_ff;
			if (wr_en && wa_eblo)
				eblo_ff <= w_byte_ff;
			if (wr_en && wa_ebhi)
				ebhi_ff <= w_byte_ff;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || watchdog_reset || standby_any)
			ovlc_ff <= `FPP_RST_OVL;
		else if (wr_en && wa_ovl)
			ovlc_ff <= w_byte_ff[3:0]; // RULE19 RULE20
	end

	// ----------------------------------------------------------
	// Flash array control outputs
	// ----------------------------------------------------------
	logic pgm_ff;
	logic ers_ff;
	logic vfy_ff;
	logic [15:0] ebe_ff;
	logic nmi_ff;
	wire nxt_pgm = p_bit && !pe_block && sw_wen_on; // RULE1 RULE2
	wire nxt_ers = e_bit && !pe_block && sw_wen_on && any_blk; // RULE3
	wire vfy_req = fctl1_ff[`FPP_FC1_PVFY] || fctl1_ff[`FPP_FC1_EVFY];
	wire nxt_vfy = vfy_req && sw_wen_on && pin_wen_ok; // RULE9 RULE4
	wire nmi_mask = in_progress || in_error; // RULE15
	wire [15:0] nxt_ebe;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_blk
			assign nxt_ebe[gi] = nxt_ers && eb_sel[gi]; // RULE2
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn || err_hit || init_all) // RULE22
		begin
			// An error aborts the running operation at once
			pgm_ff <= 1'b0; // RULE7
			ers_ff <= 1'b0;
			ebe_ff <= 16'h0000;
			vfy_ff <= 1'b0;
			nmi_ff <= 1'b0;
		end
		else
		begin
			pgm_ff <= nxt_pgm;
			ers_ff <= nxt_ers;
			ebe_ff <= nxt_ebe;
			vfy_ff <= nxt_vfy;
			nmi_ff <= nmi_in && !nmi_mask; // RULE15
		end
	end

	assign program_mode = pgm_ff;
	assign erase_mode = ers_ff;
	assign verify_mode = vfy_ff;
	assign erase_block_en = ebe_ff;
	assign nmi_out = nmi_ff;
	assign flash_error_flag = in_error; // RULE24

	// ----------------------------------------------------------
	// RAM overlay
	// ----------------------------------------------------------
	logic ovl_hit_ff;
	logic [OVL_AW-1:0] ovl_addr_ff;
	wire [FLASH_AW-OVL_AW-1:0] blk_idx = cpu_flash_addr[FLASH_AW-1:OVL_AW];
	wire [FLASH_AW-OVL_AW-1:0] sel_idx = (FLASH_AW - OVL_AW)'(ovlc_ff[2:0]);
	wire nxt_ovl_hit = emu_on && (blk_idx == sel_idx); // RULE18 RULE19 RULE20

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovl_hit_ff <= 1'b0;
			ovl_addr_ff <= '0;
		end
		else
		begin
			ovl_hit_ff <= nxt_ovl_hit;
			ovl_addr_ff <= cpu_flash_addr[OVL_AW-1:0]; // RULE18
		end
	end

	assign overlay_hit = ovl_hit_ff;
	assign overlay_ram_addr = ovl_addr_ff;

	// ----------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire ra_fc1 = s_axi_araddr == ADDR_W'(`FPP_OFS_FCTL1);
	wire ra_fc2 = s_axi_araddr == ADDR_W'(`FPP_OFS_FCTL2);
	wire ra_eblo = s_axi_araddr == ADDR_W'(`FPP_OFS_EBLO);
	wire ra_ebhi = s_axi_araddr == ADDR_W'(`FPP_OFS_EBHI);
	wire ra_ovl = s_axi_araddr == ADDR_W'(`FPP_OFS_OVLC);
	wire ra_stat = s_axi_araddr == ADDR_W'(`FPP_OFS_FSTAT);
	wire ra_hit = ra_fc1 || ra_fc2 || ra_eblo || ra_ebhi || ra_ovl || ra_stat;
	logic [7:0] stat_val;
	logic [7:0] rd_byte;

	always_comb
	begin
		stat_val = 8'h00;
		stat_val[`FPP_ST_PGM] = pgm_ff;
		stat_val[`FPP_ST_ERS] = ers_ff;
		stat_val[`FPP_ST_VFY] = vfy_ff;
		stat_val[`FPP_ST_ERR] = in_error; // RULE24
	end

	assign rd_byte = ({8{ra_fc1}} & fctl1_ff)
		| ({8{ra_fc2}} & fctl2_ff)
		| ({8{ra_eblo}} & eblo_ff)
		| ({8{ra_ebhi}} & ebhi_ff)
		| ({8{ra_ovl}} & {4'h0, ovlc_ff})
		| ({8{ra_stat}} & stat_val);

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `FPP_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte};
			rresp_ff <= ra_hit ? `FPP_RESP_OKAY : `FPP_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// Protection bits are not decoded from the bus
	wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

endmodule : fpp_top

`default_nettype wire

/* test/fpp_cpu_model.sv */
`default_nettype none
module fpp_cpu_model
	import fpp_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Bench command: kinds 0-4 one event msb first, 5 excluded exception
	input wire logic go,
	input wire logic [2:0] kind,
	// Events to the block
	output var fpp_cpu_evt_s cpu_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cpu_evt = 5'h00;
	always @(posedge aclk)
		cpu_evt <= !go ? 5'h00 : (kind == 3'h5) ? 5'h0C : 5'h10 >> kind;
endmodule : fpp_cpu_model
`default_nettype wire

/* test/fpp_top_props.sv */
`default_nettype none
module fpp_top_props
	import fpp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Conditions and events
	input wire logic write_enable_pin,
	input wire logic watchdog_reset,
	input wire logic hw_standby,
	input wire fpp_cpu_evt_s cpu_evt,
	input wire logic nmi_out,
	// Flash array control
	input wire logic program_mode,
	input wire logic erase_mode,
	input wire logic verify_mode,
	input wire logic [15:0] erase_block_en,
	input wire logic flash_error_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire busy = program_mode | erase_mode;
	wire rel = watchdog_reset | hw_standby;
	wire keep = busy & !rel;
	// ----
	// Properties
	// ----
	rd_err_a: assert property (keep && cpu_evt.flash_read |=> flash_error_flag)
		else $error("read left error clear");
	exc_err_a: assert property (keep && cpu_evt.exc_start && !cpu_evt.exc_excluded |=> flash_error_flag)
		else $error("exception left error clear");
	slp_err_a: assert property (keep && cpu_evt.sleep_exec |=> flash_error_flag)
		else $error("sleep left error clear");
	bus_err_a: assert property (keep && cpu_evt.bus_release |=> flash_error_flag)
		else $error("release left error clear");
	abort_op_a: assert property (keep && (cpu_evt.flash_read || cpu_evt.bus_release) |=> !busy)
		else $error("operation not aborted");
	err_block_a: assert property (flash_error_flag |-> !busy)
		else $error("mode during error");
	err_hold_a: assert property (flash_error_flag && !rel |=> flash_error_flag)
		else $error("error lost");
	err_rel_a: assert property (rel |=> !flash_error_flag)
		else $error("error kept on release");
	ers_sel_a: assert property (erase_mode == (|erase_block_en))
		else $error("erase enables wrong");
	pin_off_a: assert property (!write_enable_pin |=> !busy && !verify_mode)
		else $error("mode with pin low");
	nmi_mask_a: assert property (busy && $past(busy) |-> !nmi_out)
		else $error("nmi passed");
	cover property (keep && cpu_evt.flash_read);
	cover property (erase_mode);
	cover property (verify_mode && flash_error_flag);
endmodule : fpp_top_props

bind fpp_top fpp_top_props u_props (.aclk, .aresetn, .write_enable_pin, .watchdog_reset, .hw_standby, .cpu_evt,
	.nmi_out, .program_mode, .erase_mode, .verify_mode, .erase_block_en, .flash_error_flag);
`default_nettype wire

/* test/tb_fpp_top.sv */
`default_nettype none
module tb_fpp_top
	import fpp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic write_enable_pin = 1'b1, watchdog_reset = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
	logic nmi_in = 1'b0, go = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [17:0] cpu_flash_addr = 18'h0;
	logic nmi_out, program_mode, erase_mode, verify_mode, flash_error_flag, overlay_hit;
	logic [15:0] erase_block_en;
	logic [11:0] overlay_ram_addr;
	fpp_cpu_evt_s cpu_evt;
	int error_cnt = 0, check_count = 0;
	logic [31:0] seed = 32'h000064A2;

	always #4 aclk = ~aclk;

	fpp_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_enable_pin, .watchdog_reset, .hw_standby,
		.sw_standby, .cpu_evt, .nmi_in, .nmi_out, .program_mode, .erase_mode, .verify_mode, .erase_block_en,
		.flash_error_flag, .cpu_flash_addr, .overlay_hit, .overlay_ram_addr);
	fpp_cpu_model u_cpu (.aclk, .go, .kind, .cpu_evt);

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Status word from {error, verify, erase, program}
	function automatic logic [31:0] st(input logic [3:0] c);
		return {24'h0, c[3], 4'h0, c[2:0]};
	endfunction : st

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(s_axi_bvalid && s_axi_bready))
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!(s_axi_rvalid && s_axi_rready))
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp);
		chk(s_axi_rresp, er);
	endtask : rd

	task automatic ev(input logic [2:0] k);
		@(posedge aclk);
		go <= 1'b1;
		kind <= k;
		@(posedge aclk);
		go <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : ev

	// Pulse {software standby, hardware standby, watchdog reset}
	task automatic lvl(input logic [2:0] m);
		@(posedge aclk);
		{sw_standby, hw_standby, watchdog_reset} <= m;
		@(posedge aclk);
		{sw_standby, hw_standby, watchdog_reset} <= 3'h0;
	endtask : lvl

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// ----
	// Tests
	// ----
	initial
	begin
		#200000;
		error_cnt++;
		stop_test();
	end

	initial
	begin
		logic [31:0] r;
		int k;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h14, st(4'h0));
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'hFF, 2'h2);
		wr(8'h00, 32'h41);
		nmi_in <= 1'b1;
		rd(8'h14, st(4'h1));
		chk(program_mode, 1'b1);
		chk(nmi_out, 1'b0);
		wr(8'h00, 32'h40);
		repeat (3) @(posedge aclk);
		chk(nmi_out, 1'b1);
		nmi_in <= 1'b0;
		wr(8'h00, 32'h42);
		rd(8'h14, st(4'h0));
		r = xs();
		wr(r[3] ? 8'h0C : 8'h08, 32'h1 << r[2:0]);
		rd(8'h14, st(4'h2));
		chk(erase_block_en, 16'h1 << r[3:0]);
		wr(8'h00, 32'h40);
		wr(r[3] ? 8'h0C : 8'h08, 32'h0);
		$display("end entry");
		wr(8'h10, 32'h08);
		r = xs();
		cpu_flash_addr <= {6'h00, r[11:0]};
		repeat (2) @(posedge aclk);
		chk(overlay_hit, 1'b1);
		chk(overlay_ram_addr, r[11:0]);
		wr(8'h00, 32'h41);
		rd(8'h14, st(4'h0));
		wr(8'h00, 32'h44);
		rd(8'h14, st(4'h4));
		wr(8'h10, 32'h0);
		repeat (2) @(posedge aclk);
		chk(overlay_hit, 1'b0);
		$display("end overlay");
		for (k = 0; k < 6; k++)
		begin
			wr(8'h08, 32'h01);
			wr(8'h00, 32'h42);
			ev(k[2:0]);
			r = (k == 2 || k == 5) ? st(4'h2) : st(4'h8);
			rd(8'h14, r);
			chk(flash_error_flag, r[7]);
			chk(erase_mode, r[1]);
			rd(8'h08, 32'h01);
			lvl(3'h1);
			rd(8'h14, st(4'h0));
		end
		wr(8'h00, 32'h41);
		ev(3'h3);
		wr(8'h14, 32'h0);
		wr(8'h00, 32'h41);
		rd(8'h14, st(4'h8));
		wr(8'h00, 32'h44);
		rd(8'h14, st(4'hC));
		chk(verify_mode, 1'b1);
		lvl(3'h4);
		rd(8'h00, 32'h0);
		rd(8'h14, st(4'h8));
		lvl(3'h2);
		rd(8'h14, st(4'h0));
		$display("end error");
		wr(8'h00, 32'h41);
		write_enable_pin <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h14, st(4'h0));
		write_enable_pin <= 1'b1;
		wr(8'h00, 32'h01);
		rd(8'h00, 32'h0);
		$display("end pin");
		stop_test();
	end
endmodule : tb_fpp_top
`default_nettype wire
